//--- common/atm_pkg.sv
package atm_pkg;

    // Register word offsets (byte address = 4 * index)
    localparam logic [3:0] ATM_IDX_CTRL0   = 4'h0;
    localparam logic [3:0] ATM_IDX_CTRL1   = 4'h1;
    localparam logic [3:0] ATM_IDX_CNT_LO  = 4'h2;
    localparam logic [3:0] ATM_IDX_CNT_HI  = 4'h3;
    localparam logic [3:0] ATM_IDX_MA_LO   = 4'h4;
    localparam logic [3:0] ATM_IDX_MA_HI   = 4'h5;
    localparam logic [3:0] ATM_IDX_MB_LO   = 4'h6;
    localparam logic [3:0] ATM_IDX_MB_HI   = 4'h7;
    localparam logic [3:0] ATM_IDX_PERIOD  = 4'h8;
    localparam logic [3:0] ATM_IDX_FLAGS   = 4'h9;

    // Control register 0 field positions
    localparam int ATM_C0_HOLD   = 7;
    localparam int ATM_C0_TICK   = 4;
    localparam int ATM_C0_RUN    = 3;
    localparam int ATM_C0_SPK    = 0;
    localparam logic [7:0] ATM_C0_WMASK = 8'hf9;

    // Control register 1 field positions
    localparam int ATM_C1_MODE   = 6;
    localparam int ATM_C1_ACT    = 4;
    localparam int ATM_C1_INIT   = 3;
    localparam int ATM_C1_INV    = 2;
    localparam int ATM_C1_SWAP   = 1;
    localparam int ATM_C1_CLRSEL = 0;

    // Reset values
    localparam logic [7:0] ATM_CTRL_RST  = 8'h00;
    localparam logic [9:0] ATM_MATCH_RST = 10'h000;
    localparam logic [7:0] ATM_PER_RST   = 8'h00;

    // Tick source and prescale counts
    localparam logic [2:0] ATM_TK_SYS4  = 3'h0;
    localparam logic [2:0] ATM_TK_SYS   = 3'h1;
    localparam logic [2:0] ATM_TK_HI16  = 3'h2;
    localparam logic [2:0] ATM_TK_HI64  = 3'h3;
    localparam logic [2:0] ATM_TK_SLOW  = 3'h4;
    localparam logic [2:0] ATM_TK_HI    = 3'h5;
    localparam logic [2:0] ATM_TK_EXTR  = 3'h6;
    localparam logic [2:0] ATM_TK_EXTF  = 3'h7;
    localparam logic [5:0] ATM_DIV4     = 6'h03;
    localparam logic [5:0] ATM_DIV16    = 6'h0f;
    localparam logic [5:0] ATM_DIV64    = 6'h3f;
    localparam logic [9:0] ATM_CNT_MAX  = 10'h3ff;

    // Operating modes and pin actions
    localparam logic [1:0] ATM_MODE_CMP = 2'h0;
    localparam logic [1:0] ATM_MODE_PWM = 2'h2;
    localparam logic [1:0] ATM_MODE_TMR = 2'h3;
    localparam logic [1:0] ATM_ACT_NONE = 2'h0;
    localparam logic [1:0] ATM_ACT_LOW  = 2'h1;
    localparam logic [1:0] ATM_ACT_HIGH = 2'h2;
    localparam logic [1:0] ATM_ACT_TOG  = 2'h3;

    // Avalon-MM request bundle
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } atm_av_req_t;

    // Pin outputs
    typedef struct packed {
        logic out_a;
        logic out_b;
    } atm_pins_t;

endpackage

//--- src/atm_timer.sv
// Behaviour
// - Ten-bit counter counts only upward on the selected tick.
// - A and B compare all ten bits; P compares upper eight bits.
// - Software cannot write the counter; run rising edge clears it.
// - Overflow or qualifying match clears counter and raises a flag.
// - Hold bit freezes counter; clearing it resumes from held value.
// - Three-bit selector picks one of eight tick sources.
// - Run rise clears and starts; run fall stops and keeps value.
// - Run rise returns output to initial level in compare or timer mode.
// - Speaker select bit switches PWM mode to audio PWM.
// - Mode field: 00 compare, 10 PWM, 11 timer, 01 undefined.
// - Compare mode A match: keep, low, high or toggle output.
// - PWM pin action: inactive, active, or waveform.
// - Requested level equal to initial level gives no visible change.
// - Outside audio PWM, pins carry output and its complement.
// - Audio PWM drives two speaker waveforms on the pins.
// - Control 0 bits 2 and 1 read zero and ignore writes.
// - Initial-level bit: start level or PWM active polarity.
// - Invert bit inverts the output pin except in timer mode.
// - Period value zero gives 1024 ticks, else value times four.
// - Clear select: 1 clears on A match, 0 on P match/overflow.
`timescale 1ns/100ps

module atm_timer
    import atm_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Avalon-MM slave
    input  wire atm_pkg::atm_av_req_t av_req,
    output logic [31:0]              av_readdata,
    output logic                     av_waitrequest,
    // Tick sources
    input  wire logic                high_clock_tick,
    input  wire logic                slow_clock_tick,
    input  wire logic                ext_tick_pin,
    // Timer pins
    output atm_pkg::atm_pins_t       pins,
    output logic                     match_a_flag,
    output logic                     period_match_flag
);
    import atm_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [9:0] match_a_value_q;
    logic [9:0] match_b_value_q;
    logic [7:0] period_match_value_q;
    logic [9:0] count_q;
    logic       run_prev_q;
    logic       ext_prev_q;
    logic [5:0] div_sys_q;
    logic [5:0] div_hi_q;
    logic       ack_q;
    logic       prim_q;
    logic       pwm_a_q;
    logic       pwm_b_q;

    logic       count_hold;
    logic [2:0] tick_source_sel;
    logic       counter_run;
    logic       speaker_pwm_sel;
    logic [1:0] op_mode_sel;
    logic [1:0] pin_action_sel;
    logic       pin_initial_level;
    logic       pin_invert;
    logic       period_duty_swap;
    logic       clear_source_sel;

    assign count_hold        = ctrl0_q[ATM_C0_HOLD];
    assign tick_source_sel   = ctrl0_q[ATM_C0_TICK +: 3];
    assign counter_run       = ctrl0_q[ATM_C0_RUN];
    assign speaker_pwm_sel   = ctrl0_q[ATM_C0_SPK];
    assign op_mode_sel       = ctrl1_q[ATM_C1_MODE +: 2];
    assign pin_action_sel    = ctrl1_q[ATM_C1_ACT +: 2];
    assign pin_initial_level = ctrl1_q[ATM_C1_INIT];
    assign pin_invert        = ctrl1_q[ATM_C1_INV];
    assign clear_source_sel  = ctrl1_q[ATM_C1_CLRSEL];

    // Audio mode forces the swap bit off
    assign period_duty_swap  = ctrl1_q[ATM_C1_SWAP] & ~speaker_pwm_sel;

    // ****************************************
    // Bus decode
    // ****************************************
    logic wr_go;
    logic wr_lane0;
    logic run_rise;

    // One wait cycle, then the access completes
    assign wr_go    = av_req.write & ack_q;
    assign wr_lane0 = wr_go & av_req.byteenable[0];

    // Wait state toggles so each access takes two edges
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else if ((av_req.read | av_req.write) & ~ack_q)
            ack_q <= 1'b1;
        else
            ack_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            av_waitrequest <= 1'b1;
        else
            av_waitrequest <= ~((av_req.read | av_req.write) & ~ack_q);
    end

    // Control registers
    // reserved bits masked
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl0_q <= ATM_CTRL_RST;
            ctrl1_q <= ATM_CTRL_RST;
        end
        else if (wr_lane0)
        begin
            if (av_req.address == ATM_IDX_CTRL0)
                ctrl0_q <= av_req.writedata[7:0] & ATM_C0_WMASK;
            if (av_req.address == ATM_IDX_CTRL1)
                ctrl1_q <= av_req.writedata[7:0];
        end
    end

    // Match and period registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            match_a_value_q      <= ATM_MATCH_RST;
            match_b_value_q      <= ATM_MATCH_RST;
            period_match_value_q <= ATM_PER_RST;
        end
        else if (wr_lane0)
        begin
            case (av_req.address)
                ATM_IDX_MA_LO:  match_a_value_q[7:0] <= av_req.writedata[7:0];
                ATM_IDX_MA_HI:  match_a_value_q[9:8] <= av_req.writedata[1:0];
                ATM_IDX_MB_LO:  match_b_value_q[7:0] <= av_req.writedata[7:0];
                ATM_IDX_MB_HI:  match_b_value_q[9:8] <= av_req.writedata[1:0];
                ATM_IDX_PERIOD: period_match_value_q <= av_req.writedata[7:0];
                default:        ;
            endcase
        end
    end

    // Read data; unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            av_readdata <= 32'h0;
        else if ((av_req.read) & ~ack_q)
        begin
            case (av_req.address)
                ATM_IDX_CTRL0:  av_readdata <= {24'h0, ctrl0_q};
                ATM_IDX_CTRL1:  av_readdata <= {24'h0, ctrl1_q};
                ATM_IDX_CNT_LO: av_readdata <= {24'h0, count_q[7:0]};
                ATM_IDX_CNT_HI: av_readdata <= {30'h0, count_q[9:8]};
                ATM_IDX_MA_LO:  av_readdata <= {24'h0, match_a_value_q[7:0]};
                ATM_IDX_MA_HI:  av_readdata <= {30'h0, match_a_value_q[9:8]};
                ATM_IDX_MB_LO:  av_readdata <= {24'h0, match_b_value_q[7:0]};
                ATM_IDX_MB_HI:  av_readdata <= {30'h0, match_b_value_q[9:8]};
                ATM_IDX_PERIOD: av_readdata <= {24'h0, period_match_value_q};
                ATM_IDX_FLAGS:  av_readdata <= {30'h0, period_match_flag,
                                                match_a_flag};
                default:        av_readdata <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // Tick generation
    // ****************************************
    logic tick_sel;

    // Free-running prescalers from system and high clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_sys_q  <= 6'h0;
            div_hi_q   <= 6'h0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            div_sys_q  <= (div_sys_q == ATM_DIV4) ? 6'h0 : div_sys_q + 6'h1;
            if (high_clock_tick)
                div_hi_q <= div_hi_q + 6'h1;
            ext_prev_q <= ext_tick_pin;
        end
    end

    always_comb
    begin
        case (tick_source_sel)
            ATM_TK_SYS4: tick_sel = (div_sys_q == ATM_DIV4);
            ATM_TK_SYS:  tick_sel = 1'b1;
            ATM_TK_HI16: tick_sel = high_clock_tick
                                    & ((div_hi_q & ATM_DIV16) == ATM_DIV16);
            ATM_TK_HI64: tick_sel = high_clock_tick & (div_hi_q == ATM_DIV64);
            ATM_TK_SLOW: tick_sel = slow_clock_tick;
            ATM_TK_HI:   tick_sel = high_clock_tick;
            ATM_TK_EXTR: tick_sel = ext_tick_pin & ~ext_prev_q;
            ATM_TK_EXTF: tick_sel = ~ext_tick_pin & ext_prev_q;
            default:     tick_sel = 1'b0;
        endcase
    end

    // ****************************************
    // Counter and comparators
    // ****************************************
    logic       active;
    logic       step;
    logic       hit_a;
    logic       hit_p;
    logic       ovf;
    logic       clr;
    logic       set_a;
    logic       set_p;
    logic [7:0] per_lim;
    logic [9:0] duty_a;

    assign run_rise = counter_run & ~run_prev_q;

    // events only while running and not held
    assign active = counter_run & ~count_hold & ~run_rise;
    assign step   = active & tick_sel;

    // zero period means overflow at 1024
    assign hit_a   = step & (count_q == match_a_value_q);
    assign per_lim = period_match_value_q;
    assign ovf     = step & (count_q == ATM_CNT_MAX);
    assign hit_p   = step & (per_lim != 8'h0)
                     & (count_q == {per_lim - 8'h1, 2'b11});

    // clear source choice; PWM uses period, or match A when swap is set
    always_comb
    begin
        if (op_mode_sel == ATM_MODE_PWM)
            clr = period_duty_swap ? (hit_a | (match_a_value_q == 10'h0 & ovf))
                                   : (hit_p | ovf);
        else if (clear_source_sel)
            clr = hit_a | ovf;
        else
            clr = hit_p | ovf;
    end

    assign set_a = hit_a & ((match_a_value_q != 10'h0) | clear_source_sel);
    assign set_p = (hit_p | (ovf & per_lim == 8'h0)) & ~clear_source_sel;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_q <= 10'h0;
        else if (run_rise)
            count_q <= 10'h0;
        else if (clr)
            count_q <= 10'h0;
        else if (step)
            count_q <= count_q + 10'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            run_prev_q <= 1'b0;
        else
            run_prev_q <= counter_run;
    end

    // sticky flags, hardware set wins over clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            match_a_flag      <= 1'b0;
            period_match_flag <= 1'b0;
        end
        else
        begin
            if (set_a)
                match_a_flag <= 1'b1;
            else if (wr_lane0 & av_req.address == ATM_IDX_FLAGS
                     & av_req.writedata[0])
                match_a_flag <= 1'b0;
            if (set_p)
                period_match_flag <= 1'b1;
            else if (wr_lane0 & av_req.address == ATM_IDX_FLAGS
                     & av_req.writedata[1])
                period_match_flag <= 1'b0;
        end
    end

    // ****************************************
    // Output waveforms
    // ****************************************
    logic [9:0] period_cnt;
    logic       pwm_raw;

    // Duty threshold; swap moves duty onto period register
    assign duty_a     = period_duty_swap ? {per_lim, 2'b00} : match_a_value_q;
    assign period_cnt = count_q;
    assign pwm_raw    = period_cnt < duty_a;

    // compare output, reload on run rise
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prim_q <= 1'b0;
        else if (run_rise)
            prim_q <= pin_initial_level;
        else if (op_mode_sel == ATM_MODE_CMP & set_a)
        begin
            case (pin_action_sel)
                ATM_ACT_LOW:  prim_q <= 1'b0;
                ATM_ACT_HIGH: prim_q <= 1'b1;
                ATM_ACT_TOG:  prim_q <= ~prim_q;
                default:      prim_q <= prim_q;
            endcase
        end
    end

    // audio duties from A and B on shared period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
        end
        else
        begin
            pwm_a_q <= count_q < match_a_value_q;
            pwm_b_q <= count_q < match_b_value_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pins <= '0;
        else if (op_mode_sel == ATM_MODE_PWM & speaker_pwm_sel)
        begin
            pins.out_a <= pwm_a_q ^ pin_invert;
            pins.out_b <= pwm_b_q ^ pin_invert;
        end
        else if (op_mode_sel == ATM_MODE_PWM)
        begin
            case (pin_action_sel)
                ATM_ACT_NONE: pins.out_a <= ~pin_initial_level ^ pin_invert;
                ATM_ACT_LOW:  pins.out_a <= pin_initial_level ^ pin_invert;
                default:      pins.out_a <= ~(pwm_raw ^ pin_initial_level)
                                            ^ pin_invert;
            endcase
            case (pin_action_sel)
                ATM_ACT_NONE: pins.out_b <= pin_initial_level ^ pin_invert;
                ATM_ACT_LOW:  pins.out_b <= ~pin_initial_level ^ pin_invert;
                default:      pins.out_b <= (pwm_raw ^ pin_initial_level)
                                            ^ pin_invert;
            endcase
        end
        else if (op_mode_sel == ATM_MODE_CMP)
        begin
            pins.out_a <= prim_q ^ pin_invert;
            pins.out_b <= ~(prim_q ^ pin_invert);
        end
        else
        begin
            pins.out_a <= prim_q;
            pins.out_b <= ~prim_q;
        end
    end

endmodule

//--- test/atm_chk.sv
`timescale 1ns/100ps
// ****************
// Bus and pin checker
// ****************
module atm_chk
    import atm_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // Register bus
    input wire atm_pkg::atm_av_req_t av_req,
    input wire logic [31:0]          av_readdata,
    input wire logic                 av_waitrequest,
    // Tick sources
    input wire logic                 high_clock_tick,
    input wire logic                 slow_clock_tick,
    input wire logic                 ext_tick_pin,
    // Pins and flags
    input wire atm_pkg::atm_pins_t   pins,
    input wire logic                 match_a_flag,
    input wire logic                 period_match_flag
);
    logic [7:0] c0_q;
    logic [7:0] c1_q;
    logic [2:0] quiet_q;
    logic       wdone;
    logic       steady;
    logic       audio;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Completed writes to any register with byte lane 0 enabled
    assign wdone  = av_req.write && !av_waitrequest && av_req.byteenable[0];
    assign steady = quiet_q >= 3'h3;
    assign audio  = c1_q[7:6] == ATM_MODE_PWM && c0_q[ATM_C0_SPK];

    // Shadow control; pins lag writes, so settle a few cycles
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            c0_q    <= 8'h00;
            c1_q    <= 8'h00;
            quiet_q <= 3'h0;
        end
        else
        begin
            if (wdone && av_req.address == ATM_IDX_CTRL0)
                c0_q <= av_req.writedata[7:0];
            if (wdone && av_req.address == ATM_IDX_CTRL1)
                c1_q <= av_req.writedata[7:0];
            if (wdone && av_req.address <= ATM_IDX_CTRL1)
                quiet_q <= 3'h0;
            else if (quiet_q != 3'h7)
                quiet_q <= quiet_q + 3'h1;
        end
    end

    sequence s_req;
        (av_req.read || av_req.write) && av_waitrequest;
    endsequence
    sequence s_ans;
        !av_waitrequest;
    endsequence

    AST_ANSWER:
        assert property (s_req |=> s_ans)
        else $error("waitrequest did not drop after a request");
    AST_PULSE:
        assert property (s_ans |=> av_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_C0_ZERO:
        assert property (s_ans and (av_req.read &&
            av_req.address == ATM_IDX_CTRL0) |-> av_readdata[2:1] == 2'h0)
        else $error("control 0 unused bits not zero");
    AST_CNT_HI:
        assert property (s_ans and (av_req.read &&
            av_req.address == ATM_IDX_CNT_HI) |-> av_readdata[7:2] == 6'h00)
        else $error("count high byte wider than ten bits");
    AST_COMPL:
        assert property (c0_q[ATM_C0_RUN] && steady && !audio &&
            !c1_q[6] |-> pins.out_b == !pins.out_a)
        else $error("pins not complementary");
    AST_RELOAD:
        assert property ($rose(c0_q[ATM_C0_RUN]) && c1_q[7:6] == ATM_MODE_CMP
            |-> ##[1:3] pins.out_a == (c1_q[3] ^ c1_q[2]))
        else $error("run start did not reload initial level");
    AST_PWM_FORCE:
        assert property (c0_q[ATM_C0_RUN] && steady && !audio &&
            c1_q[7:6] == ATM_MODE_PWM && !c1_q[5]
            |-> pins.out_a == ((c1_q[4] ~^ c1_q[3]) ^ c1_q[2]))
        else $error("forced pwm level wrong");
    AST_OFF_QUIET:
        assert property (!c0_q[ATM_C0_RUN] && steady
            |-> !$rose(match_a_flag) && !$rose(period_match_flag))
        else $error("flag raised while off");
    AST_HOLD_QUIET:
        assert property (c0_q[ATM_C0_HOLD] && steady
            |-> !$rose(match_a_flag) && !$rose(period_match_flag))
        else $error("flag raised while held");
endmodule

bind atm_timer atm_chk CHK (.*);

//--- test/atm_spk_load.sv
`timescale 1ns/100ps
// ****************
// Speaker load: counts high cycles on each pin
// ****************
module atm_spk_load
    import atm_pkg::*;
(
    // Clock and gate
    input wire logic               clk,
    input wire logic               listen,
    // Pins under load
    input wire atm_pkg::atm_pins_t pins,
    // Measured high time
    output logic [7:0]             cnt_a,
    output logic [7:0]             cnt_b
);
    // Duty meter; cleared while not listening
    always_ff @(posedge clk)
    begin
        cnt_a <= listen ? cnt_a + {7'h00, pins.out_a} : 8'h00;
        cnt_b <= listen ? cnt_b + {7'h00, pins.out_b} : 8'h00;
    end
endmodule

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
    import atm_pkg::*;
    logic clk, rst_n, hi_tk, slow_tk, ext_pin, listen, wr, fa, fp;
    atm_av_req_t req;
    atm_pins_t   pins;
    logic [31:0] rdata;
    logic [7:0]  cnt_a, cnt_b, rd;
    logic [9:0]  cnt;
    int          error_cnt, num_checks, cyc;
    logic [7:0]  t_c1 [10] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h1c, 8'h38,
                               8'h80, 8'h90, 8'ha8, 8'hcc};
    // Expected levels: bit 1 after run start, bit 0 after match
    logic [1:0]  t_e [10] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3,
                              2'h0, 2'h2, 2'h3};
    int          t_tk [6] = '{64, 256, 8, 2, 64, 128};

    atm_timer DUT (.clk(clk), .rst_n(rst_n), .av_req(req),
        .av_readdata(rdata), .av_waitrequest(wr), .high_clock_tick(hi_tk),
        .slow_clock_tick(slow_tk), .ext_tick_pin(ext_pin), .pins(pins),
        .match_a_flag(fa), .period_match_flag(fp));
    atm_spk_load LOAD (.clk(clk), .listen(listen), .pins(pins),
        .cnt_a(cnt_a), .cnt_b(cnt_b));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Tick pulses and hang guard
    always @(posedge clk)
    begin
        cyc++;
        hi_tk   <= cyc[0];
        slow_tk <= cyc[1:0] == 2'h0;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    // One access, held until waitrequest is seen low
    task automatic bus(logic [3:0] idx, logic w, logic [7:0] d);
        req <= '{idx, !w, w, {24'h0, d}, 4'hf};
        do @(posedge clk); while (wr !== 1'b0);
        rd = rdata[7:0];
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse(int n);
        repeat (n)
        begin
            ext_pin <= 1'b1;
            repeat (2) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic rd_cnt();
        bus(ATM_IDX_CNT_LO, 1'b0, 8'h00);
        cnt[7:0] = rd;
        bus(ATM_IDX_CNT_HI, 1'b0, 8'h00);
        cnt[9:8] = rd[1:0];
    endtask

    // Audio or normal pwm run at system clock, duty measured on load
    task automatic duty(logic [7:0] c0, logic [7:0] ea, logic [7:0] eb);
        bus(ATM_IDX_CTRL0, 1'b1, 8'h10);
        bus(ATM_IDX_CTRL0, 1'b1, c0);
        repeat (8) @(posedge clk);
        listen <= 1'b1;
        repeat (40) @(posedge clk);
        listen <= 1'b0;
        // Read the meter mid-cycle, before it clears
        @(negedge clk);
        check("duty_a", cnt_a, ea);
        check("duty_b", cnt_b, eb);
        @(posedge clk);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        {rst_n, ext_pin, listen} = '0;
        req = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            bus(i[3:0], 1'b0, 8'h00);
            check("reset_val", rd, 10'h000);
        end
        bus(ATM_IDX_CTRL0, 1'b1, 8'h06);
        bus(ATM_IDX_CTRL0, 1'b0, 8'h00);
        check("ctrl0_unused", rd, 10'h000);
        bus(4'hc, 1'b1, 8'h5a);
        bus(4'hc, 1'b0, 8'h00);
        check("unmapped", rd, 10'h000);
        bus(ATM_IDX_MA_HI, 1'b1, 8'hff);
        bus(ATM_IDX_MA_HI, 1'b0, 8'h00);
        check("match_a_hi", rd, 10'h003);
        // Every internal tick source over a fixed window
        for (int c = 0; c < 6; c++)
        begin
            bus(ATM_IDX_CTRL0, 1'b1, {1'b0, c[2:0], 4'h8});
            repeat (256) @(posedge clk);
            bus(ATM_IDX_CTRL0, 1'b1, {1'b0, c[2:0], 4'h0});
            rd_cnt();
            check("tick_src", cnt + 1 >= t_tk[c] && cnt <= t_tk[c] + 6, 1);
        end
        // External ticks: run, hold, stop, write attempt
        bus(ATM_IDX_MA_HI, 1'b1, 8'h00);
        bus(ATM_IDX_CTRL0, 1'b1, 8'h68);
        pulse(5);
        rd_cnt();
        check("ext_rise", cnt, 10'd5);
        bus(ATM_IDX_CTRL0, 1'b1, 8'he8);
        pulse(3);
        rd_cnt();
        check("held", cnt, 10'd5);
        bus(ATM_IDX_CTRL0, 1'b1, 8'h68);
        pulse(2);
        rd_cnt();
        check("resumed", cnt, 10'd7);
        bus(ATM_IDX_CTRL0, 1'b1, 8'h60);
        pulse(2);
        bus(ATM_IDX_CNT_LO, 1'b1, 8'h55);
        rd_cnt();
        check("stopped", cnt, 10'd7);
        bus(ATM_IDX_CTRL0, 1'b1, 8'h78);
        pulse(4);
        rd_cnt();
        check("ext_fall", cnt, 10'd4);
        // Pin actions with match A at 2, period 4 ticks
        bus(ATM_IDX_MA_LO, 1'b1, 8'h02);
        bus(ATM_IDX_PERIOD, 1'b1, 8'h01);
        for (int i = 0; i < 10; i++)
        begin
            bus(ATM_IDX_CTRL0, 1'b1, 8'h60);
            bus(ATM_IDX_CTRL1, 1'b1, t_c1[i]);
            bus(ATM_IDX_FLAGS, 1'b1, 8'h03);
            bus(ATM_IDX_CTRL0, 1'b1, 8'h68);
            repeat (3) @(posedge clk);
            check("pin_start", pins.out_a, t_e[i][1]);
            pulse(3);
            check("pin_match", pins.out_a, t_e[i][0]);
            check("pin_compl", pins.out_b, !t_e[i][0]);
            if (t_c1[i][6] | !t_c1[i][7])
                check("flag_a", fa, 1);
        end
        // Clear sources
        for (int s = 0; s < 2; s++)
        begin
            bus(ATM_IDX_CTRL0, 1'b1, 8'h60);
            bus(ATM_IDX_CTRL1, 1'b1, {7'h00, !s[0]});
            bus(ATM_IDX_FLAGS, 1'b1, 8'h03);
            bus(ATM_IDX_CTRL0, 1'b1, 8'h68);
            pulse(3 + s);
            rd_cnt();
            check("cleared", cnt, 10'd0);
            check("flag_p", fp, s[0]);
        end
        pulse(1);
        rd_cnt();
        check("after_clear", cnt, 10'd1);
        // Audio against normal pwm: duty A=1, B=2, period 4
        bus(ATM_IDX_MA_LO, 1'b1, 8'h01);
        bus(ATM_IDX_MB_LO, 1'b1, 8'h02);
        bus(ATM_IDX_CTRL0, 1'b1, 8'h10);
        bus(ATM_IDX_CTRL1, 1'b1, 8'ha8);
        duty(8'h19, 8'd10, 8'd20);
        duty(8'h18, 8'd10, 8'd30);
        conclude();
    end
endmodule
